// ==== include/mseq_maint_pkg.sv ====
// Package for the microsequencer maintenance control register bank.
package mseq_maint_pkg;

    // Bus geometry.
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 16;
    localparam int unsigned SEL_W = 4;

    // Word byte offsets.
    localparam logic [ADDR_W-1:0] OFF_SYS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SPEC_FUNC = 4'h4;

    // Field positions of the system control register.
    localparam int unsigned BIT_RUN = 0;
    localparam int unsigned BIT_STEP = 1;
    localparam int unsigned BIT_BR_DIS = 2;
    localparam int unsigned BIT_DATA_SRC = 3;
    localparam int unsigned BIT_AUX_LO = 7;
    localparam int unsigned BIT_MAINT = 9;
    localparam int unsigned BIT_AUX_HI = 15;

    // Byte lanes that cover the 16-bit registers.
    localparam int unsigned LANE_LO = 0;
    localparam int unsigned LANE_HI = 1;
    localparam logic [1:0] LANES_FULL = 2'h3;

    // Reset values.
    localparam logic [REG_W-1:0] RST_SPEC_FUNC = 16'h0000;
    localparam logic [REG_W-1:0] RST_ROM_DATA = 16'h0000;
    localparam logic [REG_W-1:0] RD_ZERO = 16'h0000;

    // Control levels handed to the microsequencer.
    typedef struct packed {
        logic run;
        logic step;
        logic branch_dis;
        logic data_src;
    } seq_ctl_t;

    // System maintenance levels.
    typedef struct packed {
        logic maint;
        logic aux_lo;
        logic aux_hi;
    } maint_ctl_t;

endpackage

// ==== hw/mseq_maint.sv ====
// Maintenance control bits and ROM data register for the microsequencer.
//
// How it works
// - Microsequencer runs the data section only while the run or step bit is one.
// - Writing the step bit one lets exactly one ROM cycle run, then halt.
// - The step bit clears itself when the stepped ROM cycle begins.
// - While branch-disable is one, every microsequencer branch is suppressed.
// - While data-source-select is one, host writes load the special register.
// - With data-source-select set, the special register replaces the ROM word.
// - Maintenance bit 09 makes bits 07 and 15 writable; reset clears it.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module mseq_maint
    import mseq_maint_pkg::*;
#(
    parameter int unsigned ROM_W = REG_W
)
(
    // Clock, reset and freeze.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Wishbone classic slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Microsequencer side.
    input wire logic rom_cycle_begin,
    input wire logic branch_req,
    input wire logic [ROM_W-1:0] rom_word,
    output logic rom_cycle_en,
    output logic branch_take,
    output logic [ROM_W-1:0] rom_data_q,
    output seq_ctl_t seq_ctl,
    output maint_ctl_t maint_ctl
);

    // Address match used by both the read and the write path.
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    // Control word as the host reads it; unused positions read as zero.
    function automatic logic [REG_W-1:0] pack_ctrl(input seq_ctl_t s,
                                                   input maint_ctl_t m);
        logic [REG_W-1:0] w;
        w = RD_ZERO;
        w[BIT_RUN] = s.run;
        w[BIT_STEP] = s.step;
        w[BIT_BR_DIS] = s.branch_dis;
        w[BIT_DATA_SRC] = s.data_src;
        w[BIT_AUX_LO] = m.aux_lo;
        w[BIT_MAINT] = m.maint;
        w[BIT_AUX_HI] = m.aux_hi;
        pack_ctrl = w;
    endfunction

    logic run_q;
    logic step_q;
    logic br_dis_q;
    logic data_src_q;
    logic maint_q;
    logic aux_lo_q;
    logic aux_hi_q;
    logic [REG_W-1:0] spec_func_q;
    logic ack_q;

    // Bus decode: one access is taken on the edge where ack is raised.
    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wr = req && wb_we_i && ce;
    wire logic hit_ctrl = hit(wb_adr_i, OFF_SYS_CTRL);
    wire logic hit_spec = hit(wb_adr_i, OFF_SPEC_FUNC);
    wire logic lane_lo = wb_sel_i[LANE_LO];
    wire logic lane_hi = wb_sel_i[LANE_HI];
    wire logic full_word = (wb_sel_i[1:0] == LANES_FULL);
    // byte guard
    // A byte cycle in maintenance mode is dropped, so a stray half write
    // cannot disturb bits 07 and 15 while they are exposed.
    wire logic ctrl_ok = !maint_q || full_word;
    wire logic wr_ctrl_lo = wr && hit_ctrl && lane_lo && ctrl_ok;
    wire logic wr_ctrl_hi = wr && hit_ctrl && lane_hi && ctrl_ok;
    wire logic wr_spec = wr && hit_spec && data_src_q;
    wire logic aux_wr_lo = wr_ctrl_lo && maint_q;
    wire logic aux_wr_hi = wr_ctrl_hi && maint_q;

    wire logic cycle_ok = run_q || step_q;
    wire logic branch_ok = branch_req && !br_dis_q;
    wire logic [ROM_W-1:0] rom_src = data_src_q ?
        ROM_W'(spec_func_q) : rom_word;

    // Read mux; unmapped offsets read as zero.
    wire logic [REG_W-1:0] ctrl_rd = pack_ctrl(seq_ctl, maint_ctl);
    wire logic [REG_W-1:0] rd_word = hit_ctrl ? ctrl_rd :
        (hit_spec ? spec_func_q : RD_ZERO);

    // Step bit next value. A host write of one wins over the self clear,
    // so a new step request arriving with a cycle start is not lost.
    // step self clear
    wire logic step_set = wr_ctrl_lo && wb_dat_i[BIT_STEP];
    wire logic step_clr = rom_cycle_begin && step_q
        || (wr_ctrl_lo && !wb_dat_i[BIT_STEP]);
    wire logic step_d = step_set || (step_q && !step_clr);

    // Bus acknowledge, one cycle per access, dropped on the next cycle.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ack_q <= 1'b0;
        else if (ce)
            ack_q <= req;
    end

    // Read data register, loaded as the ack is raised.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= '0;
        else if (ce && req)
            wb_dat_o <= DATA_W'(rd_word);
    end

    // Low control byte: run, step, branch disable, data source, bit 07.
    // readback storage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            run_q <= 1'b0;
            step_q <= 1'b0;
            br_dis_q <= 1'b0;
            data_src_q <= 1'b0;
            aux_lo_q <= 1'b0;
        end
        else if (ce)
        begin
            step_q <= step_d;
            if (wr_ctrl_lo)
            begin
                run_q <= wb_dat_i[BIT_RUN];
                br_dis_q <= wb_dat_i[BIT_BR_DIS];
                data_src_q <= wb_dat_i[BIT_DATA_SRC];
            end
            if (aux_wr_lo)
                aux_lo_q <= wb_dat_i[BIT_AUX_LO];
        end
    end

    // High control byte: maintenance mode and bit 15.
    // Bit 15 looks at the mode held before this write, so setting the mode
    // and bit 15 together needs two writes.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            maint_q <= 1'b0;
            aux_hi_q <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_ctrl_hi)
                maint_q <= wb_dat_i[BIT_MAINT];
            if (aux_wr_hi)
                aux_hi_q <= wb_dat_i[BIT_AUX_HI];
        end
    end

    // Special function register, byte lane writes honoured.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            spec_func_q <= RST_SPEC_FUNC;
        else if (ce && wr_spec)
        begin
            if (lane_lo)
                spec_func_q[7:0] <= wb_dat_i[7:0];
            if (lane_hi)
                spec_func_q[15:8] <= wb_dat_i[15:8];
        end
    end

    // ROM data register, loaded at the start of each ROM cycle.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rom_data_q <= ROM_W'(RST_ROM_DATA);
        else if (ce && rom_cycle_begin)
            rom_data_q <= rom_src;
    end

    // Outputs to the bus and the microsequencer.
    assign wb_ack_o = ack_q;
    assign rom_cycle_en = cycle_ok;
    assign branch_take = branch_ok;
    assign seq_ctl = '{run: run_q, step: step_q, branch_dis: br_dis_q,
                       data_src: data_src_q};
    assign maint_ctl = '{maint: maint_q, aux_lo: aux_lo_q,
                         aux_hi: aux_hi_q};

    // Checks on the control bits.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_run_gates_cycles: assert property (
        !run_q && !step_q |-> !rom_cycle_en)
        else $error("ROM cycles enabled with run and step clear");

    a_step_one_cycle: assert property (
        ce && step_q && !run_q && rom_cycle_begin && !step_set
        |=> !rom_cycle_en)
        else $error("More than one ROM cycle after a single step");

    a_step_self_clr: assert property (
        ce && rom_cycle_begin && step_q && !step_set |=> !step_q)
        else $error("Step bit not cleared at ROM cycle start");

    a_step_set_wr: assert property (
        ce && step_set |=> step_q)
        else $error("Step bit write of one lost");

    a_branch_blocked: assert property (
        br_dis_q |-> !branch_take)
        else $error("Branch taken while branches disabled");

    a_spec_hold: assert property (
        !data_src_q |=> $stable(spec_func_q))
        else $error("Special register changed with data source clear");

    a_rom_from_spec: assert property (
        ce && rom_cycle_begin && data_src_q
        |=> rom_data_q == ROM_W'($past(spec_func_q)))
        else $error("ROM data not taken from the special register");

    a_aux_locked: assert property (
        !maint_q |=> $stable(aux_lo_q) && $stable(aux_hi_q))
        else $error("Bits 07 or 15 changed outside maintenance mode");

    a_byte_dropped: assert property (
        maint_q && ce && req && wb_we_i && hit_ctrl && !full_word
        |=> $stable(ctrl_rd) || $past(rom_cycle_begin))
        else $error("Byte write changed control in maintenance mode");

    a_ctrl_readback: assert property (
        ce && req && hit_ctrl |=> wb_ack_o ##0
        wb_dat_o[REG_W-1:0] == $past(ctrl_rd))
        else $error("Control register read returned wrong value");

    // Bus answers in exactly one cycle and drops ack after it.
    a_ack_single: assert property (
        ce && req |=> wb_ack_o ##1 (!wb_ack_o || !ce))
        else $error("Acknowledge not a single cycle");

    a_aux_written: assert property (
        ce && aux_wr_hi |=> aux_hi_q == $past(wb_dat_i[BIT_AUX_HI]))
        else $error("Bit 15 write lost in maintenance mode");

    a_rom_from_word: assert property (
        ce && rom_cycle_begin && !data_src_q
        |=> rom_data_q == $past(rom_word))
        else $error("ROM data not taken from the ROM word");

    a_spec_loaded: assert property (
        ce && wr_spec && full_word
        |=> spec_func_q == $past(wb_dat_i[REG_W-1:0]))
        else $error("Special register write lost");

    // With the enable low no control bit or ack may move, so a paused
    // sequencer finds the same levels when it resumes.
    a_freeze_hold: assert property (
        !ce |=> $stable(seq_ctl) && $stable(maint_ctl) && $stable(wb_ack_o))
        else $error("State changed while the clock enable was low");

    // Main scenarios.
    c_step_run: cover property (step_set ##[1:20] rom_cycle_begin);
    c_spec_inject: cover property (wr_spec ##[1:20]
        (rom_cycle_begin && data_src_q));
    c_branch_cut: cover property (branch_req && br_dis_q);
    c_maint_write: cover property (aux_wr_hi);
    c_freeze_req: cover property (!ce && wb_cyc_i);

endmodule

// ==== dv/seq_model.sv ====
// Behavioural microsequencer that starts ROM cycles and offers branches.
`timescale 1ns/1ps
module seq_model
(
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Control from the block; gap sets how slowly cycles start.
    input wire logic rom_cycle_en,
    input wire logic [3:0] gap,
    // Microsequencer outputs.
    output logic rom_cycle_begin,
    output logic branch_req,
    output logic [15:0] rom_word
);
    logic [3:0] cnt_q;
    logic fire;
    // Never two starts in a row, so a single step cannot be doubled.
    // gated cycle start
    assign fire = rom_cycle_en && cnt_q == gap && !rom_cycle_begin;
    // The word changes every cycle; the branch request follows its bit 3.
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= 4'h0;
            rom_cycle_begin <= 1'b0;
            rom_word <= 16'h0000;
        end
        else
        begin
            rom_cycle_begin <= fire;
            cnt_q <= (!rom_cycle_en || fire) ? 4'h0 : cnt_q + 4'h1;
            rom_word <= rom_word + 16'h1357;
        end
    end
    assign branch_req = rom_word[3];
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the maintenance control register bank.
`timescale 1ns/1ps
module tb;
    import mseq_maint_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic [SEL_W-1:0] sel = 4'h0;
    logic [DATA_W-1:0] wdat = 32'h0;
    logic [DATA_W-1:0] rdat, dat_o;
    logic ack, begin_p, br_req, en, take;
    logic [15:0] word, rom_q, last_word;
    logic [3:0] gap = 4'h1;
    seq_ctl_t sc;
    maint_ctl_t mc;
    int bad_count = 0;
    int n_tests = 0;
    int n_begin = 0;
    mseq_maint i_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .rom_cycle_begin(begin_p), .branch_req(br_req), .rom_word(word),
        .rom_cycle_en(en), .branch_take(take), .rom_data_q(rom_q),
        .seq_ctl(sc), .maint_ctl(mc));
    seq_model i_seq (.clk(clk), .arst_n(arst_n), .rom_cycle_en(en),
        .gap(gap), .rom_cycle_begin(begin_p), .branch_req(br_req),
        .rom_word(word));
    // Free-running clock at 100 MHz.
    initial
    begin
        forever #5 clk = ~clk;
    end
    // Count cycle starts and keep the ROM word each one fetched.
    always @(posedge clk)
    begin
        if (begin_p === 1'b1)
        begin
            n_begin++;
            last_word <= word;
        end
    end
    task automatic complete_run;
        if (bad_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One classic cycle; the request holds until ack is sampled high.
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
        input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] d);
        int i;
        i = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (ack !== 1'b1 && i < 20);
        rdat = dat_o;
        cyc <= 1'b0;
        if (ack !== 1'b1)
        begin
            bad_count++;
            $display("mismatch at %0t: no bus acknowledge", $time);
            complete_run();
        end
    endtask
    // Full-word writes only, which maintenance mode demands.
    // full word access
    task automatic wr(input logic [15:0] v);
        bus(1'b1, OFF_SYS_CTRL, 4'hF, {16'h0000, v});
    endtask
    task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        bus(1'b0, a, 4'hF, 32'h0);
        check(rdat, {16'h0000, e});
    endtask
    task automatic step_once(input logic [15:0] v);
        n_begin = 0;
        wr(v | 16'h0002);
        for (int i = 0; i < 30 && n_begin == 0; i++)
            @(posedge clk);
        if (n_begin == 0)
        begin
            bad_count++;
            $display("mismatch at %0t: no ROM cycle start", $time);
            complete_run();
        end
        repeat (6) @(posedge clk);
        #1;
        check(n_begin, 1);
        check(en, 1'b0);
        check(sc.step, 1'b0);
    endtask
    task automatic t_reset;
        rd_check(OFF_SYS_CTRL, 16'h0000);
        check(en, 1'b0);
    endtask
    task automatic t_run;
        wr(16'h0001);
        rd_check(OFF_SYS_CTRL, 16'h0001);
        check(sc.run, 1'b1);
        repeat (8) @(posedge clk);
        check(n_begin > 2, 1'b1);
        wr(16'h0000);
        // A start launched while run was still set lands one edge later.
        @(posedge clk);
        n_begin = 0;
        repeat (6) @(posedge clk);
        check(n_begin, 0);
    endtask
    task automatic t_step;
        gap <= 4'h3;
        step_once(16'h0000);
        rd_check(OFF_SYS_CTRL, 16'h0000);
        check(rom_q, last_word);
    endtask
    task automatic t_branch;
        for (int d = 1; d >= 0; d--)
        begin
            wr(d[0] ? 16'h0004 : 16'h0000);
            check(sc.branch_dis, d[0]);
            repeat (6)
            begin
                @(posedge clk);
                #1;
                check(take, br_req & ~d[0]);
            end
        end
    endtask
    task automatic t_source;
        bus(1'b1, OFF_SPEC_FUNC, 4'hF, 32'h00005A3C);
        step_once(16'h0008);
        check(rom_q, 16'h0000);
        bus(1'b1, OFF_SPEC_FUNC, 4'hF, 32'h0000C3A5);
        step_once(16'h0008);
        check(rom_q, 16'hC3A5);
        rd_check(OFF_SYS_CTRL, 16'h0008);
        rd_check(OFF_SPEC_FUNC, 16'hC3A5);
        check(sc.data_src, 1'b1);
    endtask
    // A write held while the enable is low must wait for the enable.
    task automatic t_freeze;
        @(posedge clk);
        ce <= 1'b0;
        fork
            bus(1'b1, OFF_SYS_CTRL, 4'hF, 32'h00000004);
            begin
                repeat (4) @(posedge clk);
                check(ack, 1'b0);
                check(sc.branch_dis, 1'b0);
                ce <= 1'b1;
            end
        join
        check(sc.branch_dis, 1'b1);
    endtask
    task automatic t_maint;
        wr(16'h8080);
        rd_check(OFF_SYS_CTRL, 16'h0000);
        check(mc.aux_hi, 1'b0);
        wr(16'h0200);
        wr(16'h8280);
        rd_check(OFF_SYS_CTRL, 16'h8280);
        check(mc.maint, 1'b1);
        check(mc.aux_lo, 1'b1);
        check(mc.aux_hi, 1'b1);
        bus(1'b1, OFF_SYS_CTRL, 4'h1, 32'h0);
        rd_check(OFF_SYS_CTRL, 16'h8280);
        rd_check(4'h8, 16'h0000);
    endtask
    // Reset for 20 cycles, then run each scenario in turn.
    initial
    begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_run();
        t_step();
        t_branch();
        t_source();
        t_freeze();
        t_maint();
        complete_run();
    end
endmodule
